// ===== logic/pccse_engine.sv
//////////////////////////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////////////////////////
//
// The register offsets and register access over APB were chosen for this implementation.
`timescale 1ns/10ps
`include "pccse_params.svh"
module pccse_engine import pccse_pkg::*; (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic      [25:0] system_address_bus,
  input  wire logic [15:0] system_data_bus_in,
  output logic      [15:0] system_data_bus_out,
  output logic             system_data_bus_oe,
  input  wire logic        card_stretch_request_n,
  input  wire logic        card_io_word_indication_n,
  output pccse_pins_t      card_pins
);
  localparam logic [7:0] TSTD = 8'(`PCCSE_T_STD_CYC);
  localparam logic [7:0] TENH = 8'(`PCCSE_T_ENH_CYC);

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [15:0] sd_s;
  logic [1:0]  ctl_s;
  logic        wait_s;
  logic        io16_s;

  pccse_sync #(.W(16)) u_sync_sd (
    .clk      (clk),
    .rst      (rst),
    .async_in (system_data_bus_in),
    .sync_out (sd_s)
  );
  pccse_sync #(.W(2)) u_sync_ctl (
    .clk      (clk),
    .rst      (rst),
    .async_in ({~card_stretch_request_n, ~card_io_word_indication_n}),
    .sync_out (ctl_s)
  );
  assign wait_s = ctl_s[1];
  assign io16_s = ctl_s[0];

  //////////////////////////////////////////////////////////////////////////////////////////////
  // APB register file
  logic [2:0]   ctrl_reg, ctrl_next;
  pccse_tset_t  tset_reg [4];
  pccse_tset_t  tset_next [4];
  logic [25:0]  addr_reg, addr_next;
  logic [15:0]  wdata_reg, wdata_next;
  logic [31:0]  prdata_next;
  logic         pready_next, pslverr_next;
  logic         go;
  pccse_cmd_t   go_cmd;
  logic         busy;
  logic         io_seen_reg, io_seen_next;
  logic [15:0]  rdata_reg, rdata_next;
  pccse_state_t state_reg, state_next;
  pccse_tset_t  ts_rd;

  // Timing set addressed by the bus; fields read back at their write positions
  assign ts_rd = tset_reg[2'(paddr[7:2] - 6'h1)];

  assign busy   = (state_reg != ST_IDLE);
  assign go_cmd = pccse_cmd_t'(pwdata[6:0]);

  // Answer one cycle after setup; writes land on the access edge with pready high
  always_comb begin
    ctrl_next    = ctrl_reg;
    tset_next    = tset_reg;
    addr_next    = addr_reg;
    wdata_next   = wdata_reg;
    prdata_next  = 32'h0;
    pready_next  = 1'b0;
    pslverr_next = 1'b0;
    go           = 1'b0;
    if (psel && !penable) begin
      pready_next = 1'b1;
      if (paddr == `PCCSE_OFS_CTRL) begin
        prdata_next = {29'h0, ctrl_reg};
      end else if (paddr >= `PCCSE_OFS_TSET0 && paddr <= `PCCSE_OFS_TSET3
                   && paddr[1:0] == 2'h0) begin
        prdata_next = {10'h0, ts_rd.r, 2'h0, ts_rd.c, 2'h0, ts_rd.s};
      end else if (paddr == `PCCSE_OFS_ADDR) begin
        prdata_next = {6'h0, addr_reg};
      end else if (paddr == `PCCSE_OFS_WDATA) begin
        prdata_next = {16'h0, wdata_reg};
      end else if (paddr == `PCCSE_OFS_CMD) begin
        prdata_next = 32'h0;
      end else if (paddr == `PCCSE_OFS_STATUS) begin
        prdata_next = {rdata_reg, 14'h0, io_seen_reg, busy};
      end else begin
        pslverr_next = 1'b1;
      end
    end
    if (psel && penable && pready && pwrite && !pslverr) begin
      if (paddr == `PCCSE_OFS_CTRL) begin
        ctrl_next = pwdata[2:0];
      end else if (paddr >= `PCCSE_OFS_TSET0 && paddr <= `PCCSE_OFS_TSET3) begin
        tset_next[2'(paddr[7:2] - 6'h1)] =
          pccse_tset_t'({pwdata[21:16], pwdata[13:8], pwdata[5:0]});
      end else if (paddr == `PCCSE_OFS_ADDR) begin
        addr_next = pwdata[25:0];
      end else if (paddr == `PCCSE_OFS_WDATA) begin
        wdata_next = pwdata[15:0];
      end else if (paddr == `PCCSE_OFS_CMD) begin
        go = !busy;                              // Ignored while a cycle runs
      end
    end
  end

  // APB registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_reg  <= `PCCSE_CTRL_RST;
      tset_reg  <= '{default: `PCCSE_TSET_RST};
      addr_reg  <= 26'h0;
      wdata_reg <= 16'h0;
      prdata    <= 32'h0;
      pready    <= 1'b0;
      pslverr   <= 1'b0;
    end else begin
      ctrl_reg  <= ctrl_next;
      tset_reg  <= tset_next;
      addr_reg  <= addr_next;
      wdata_reg <= wdata_next;
      prdata    <= prdata_next;
      pready    <= pready_next;
      pslverr   <= pslverr_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Cycle engine
  pccse_cmd_t  cmd_reg, cmd_next;
  pccse_pins_t pins_next;
  logic [7:0]  cnt_reg, cnt_next;
  logic [7:0]  rel_reg, rel_next;
  logic [7:0]  hi_reg, hi_next;
  logic [7:0]  tcyc_reg, tcyc_next;
  logic [7:0]  len_s_reg, len_s_next, len_c_reg, len_c_next, len_r_reg, len_r_next;
  logic [1:0]  tc_reg, tc_next;
  logic [25:0] sa_next;
  logic [15:0] sd_out_next;
  logic        sd_oe_next;
  logic [7:0]  tcyc_sel;
  pccse_tset_t ts_sel;

  // Zero counts are taken as one period so a phase is never skipped
  function automatic logic [7:0] plen(input logic [5:0] n, input logic [7:0] t);
    logic [13:0] prod;
    prod = 14'((n == 6'h0) ? 6'h1 : n) * 14'(t);
    return 8'(prod);
  endfunction

  // Lane enables, shared by memory, I/O and DMA cycles
  function automatic pccse_pins_t lanes(input pccse_pins_t p, input pccse_cmd_t c);
    pccse_pins_t q;
    q = p;
    q.ce_lo_n[c.socket] = (c.width == WID_HIGH);
    q.ce_hi_n[c.socket] = (c.width == WID_BYTE);
    return q;
  endfunction

  assign tcyc_sel = ctrl_reg[`PCCSE_CTRL_ENH_BIT] ? TENH : TSTD;
  assign ts_sel   = tset_reg[ctrl_reg[2:1]];

  always_comb begin
    state_next   = state_reg;
    cmd_next     = cmd_reg;
    pins_next    = card_pins;
    cnt_next     = (cnt_reg != 8'h0) ? cnt_reg - 8'h1 : 8'h0;
    rel_next     = rel_reg;
    hi_next      = hi_reg;
    tcyc_next    = tcyc_reg;
    len_s_next   = len_s_reg;
    len_c_next   = len_c_reg;
    len_r_next   = len_r_reg;
    tc_next      = tc_reg;
    sa_next      = system_address_bus;
    sd_out_next  = system_data_bus_out;
    sd_oe_next   = system_data_bus_oe;
    rdata_next   = rdata_reg;
    io_seen_next = io_seen_reg;
    case (state_reg)
      ST_IDLE: begin
        if (go) begin
          cmd_next     = go_cmd;
          tcyc_next    = tcyc_sel;
          len_s_next   = plen(ts_sel.s, tcyc_sel);
          len_c_next   = plen(ts_sel.c, tcyc_sel);
          len_r_next   = plen(ts_sel.r, tcyc_sel);
          hi_next      = tcyc_sel - 8'h1;
          rel_next     = 8'h0;
          io_seen_next = 1'b0;
          sa_next      = addr_reg;
          sd_out_next  = wdata_reg;
          sd_oe_next   = go_cmd.write;
          pins_next    = lanes(card_pins, go_cmd);
          if (go_cmd.kind == KIND_DMA) begin
            pins_next.dack_n = 1'b0;
            cnt_next   = 8'(`PCCSE_DACK_SU_CYC) - 8'h1;
            state_next = ST_DMA_ACK;
          end else begin
            pins_next.reg_n[go_cmd.socket] = (go_cmd.kind == KIND_COMMON);
            cnt_next   = plen(ts_sel.s, tcyc_sel) - 8'h1;
            state_next = ST_SETUP;
          end
        end
      end
      ST_SETUP, ST_CMD: begin
        // A word indication on I/O widens the access one period later
        if (cmd_reg.kind == KIND_IO && io16_s) begin
          io_seen_next = 1'b1;
          if (hi_reg == 8'h0) begin
            pins_next.ce_hi_n[cmd_reg.socket] = 1'b0;
          end else begin
            hi_next = hi_reg - 8'h1;
          end
        end
        if (state_reg == ST_SETUP) begin
          if (cnt_reg == 8'h0) begin
            cnt_next         = len_c_reg - 8'h1;
            pins_next.oe_n   = !(cmd_reg.kind != KIND_IO && !cmd_reg.write);
            pins_next.we_n   = !(cmd_reg.kind != KIND_IO && cmd_reg.write);
            pins_next.ior_n  = !(cmd_reg.kind == KIND_IO && !cmd_reg.write);
            pins_next.iow_n  = !(cmd_reg.kind == KIND_IO && cmd_reg.write);
            state_next       = ST_CMD;
          end
        end else begin
          // Wait reloads the tail so the command outlives its release
          if (wait_s) begin
            rel_next = 8'(tcyc_reg << 1);
          end else if (rel_reg != 8'h0) begin
            rel_next = rel_reg - 8'h1;
          end
          if (cnt_reg == 8'h0 && !wait_s && rel_reg == 8'h0) begin
            rdata_next = sd_s;
            pins_next.oe_n  = 1'b1;
            pins_next.we_n  = 1'b1;
            pins_next.ior_n = 1'b1;
            pins_next.iow_n = 1'b1;
            cnt_next   = len_r_reg - 8'h1;
            state_next = ST_RECOV;
          end
        end
      end
      ST_RECOV: begin
        if (cnt_reg == 8'h0) begin
          pins_next.ce_hi_n = 2'h3;
          pins_next.ce_lo_n = 2'h3;
          pins_next.reg_n   = 2'h3;
          sd_oe_next        = 1'b0;
          state_next        = ST_IDLE;
        end
      end
      ST_DMA_ACK: begin
        if (cnt_reg == 8'h0) begin
          pins_next.ior_n = cmd_reg.write;
          pins_next.iow_n = !cmd_reg.write;
          cnt_next = cmd_reg.write ? 8'(`PCCSE_DMA_WR_CYC) - 8'h1
                                   : 8'(`PCCSE_DMA_RD_CYC) - 8'h1;
          tc_next    = 2'(`PCCSE_TC_DLY_CYC + `PCCSE_TC_W_CYC);
          state_next = ST_DMA_CMD;
        end
      end
      ST_DMA_CMD: begin
        // Counts down through the delay, then holds terminal count for its width
        if (tc_reg != 2'h0) begin
          tc_next = tc_reg - 2'h1;
        end
        pins_next.tc_n = !(cmd_reg.last && tc_reg != 2'h0
                           && tc_reg <= 2'(`PCCSE_TC_W_CYC));
        if (cnt_reg == 8'h0 && tc_reg == 2'h0) begin
          rdata_next      = sd_s;
          pins_next.ior_n = 1'b1;
          pins_next.iow_n = 1'b1;
          pins_next.tc_n  = 1'b1;
          cnt_next   = 8'(`PCCSE_DACK_HOLD_CYC) - 8'h1;
          state_next = ST_DMA_HOLD;
        end
      end
      ST_DMA_HOLD: begin
        if (cnt_reg == 8'h0) begin
          pins_next.dack_n  = 1'b1;
          pins_next.ce_hi_n = 2'h3;
          pins_next.ce_lo_n = 2'h3;
          sd_oe_next        = 1'b0;
          state_next        = ST_IDLE;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  // Engine registers; all card pins come straight from here
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg           <= ST_IDLE;
      cmd_reg             <= '0;
      card_pins           <= '1;
      cnt_reg             <= 8'h0;
      rel_reg             <= 8'h0;
      hi_reg              <= 8'h0;
      tcyc_reg            <= TSTD;
      len_s_reg           <= 8'h0;
      len_c_reg           <= 8'h0;
      len_r_reg           <= 8'h0;
      tc_reg              <= 2'h0;
      system_address_bus  <= 26'h0;
      system_data_bus_out <= 16'h0;
      system_data_bus_oe  <= 1'b0;
      rdata_reg           <= 16'h0;
      io_seen_reg         <= 1'b0;
    end else begin
      state_reg           <= state_next;
      cmd_reg             <= cmd_next;
      card_pins           <= pins_next;
      cnt_reg             <= cnt_next;
      rel_reg             <= rel_next;
      hi_reg              <= hi_next;
      tcyc_reg            <= tcyc_next;
      len_s_reg           <= len_s_next;
      len_c_reg           <= len_c_next;
      len_r_reg           <= len_r_next;
      tc_reg              <= tc_next;
      system_address_bus  <= sa_next;
      system_data_bus_out <= sd_out_next;
      system_data_bus_oe  <= sd_oe_next;
      rdata_reg           <= rdata_next;
      io_seen_reg         <= io_seen_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Assertions
  logic       cmd_act;
  logic [7:0] dwell_reg;
  assign cmd_act = !(card_pins.oe_n && card_pins.we_n && card_pins.ior_n && card_pins.iow_n);

  // Cycles spent in the current state, saturating
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dwell_reg <= 8'h0;
    end else begin
      dwell_reg <= (state_next != state_reg) ? 8'h0
                   : ((dwell_reg == 8'hff) ? dwell_reg : dwell_reg + 8'h1);
    end
  end

  sequence s_dack_lead;
    $fell(card_pins.dack_n) ##0 !cmd_act [*3];
  endsequence
  sequence s_tc_pulse;
    !card_pins.tc_n [*2];
  endsequence

  AST_SETUP_LEN: assert property (@(posedge clk) disable iff (rst)
    (state_reg == ST_SETUP && state_next == ST_CMD) |-> (9'(dwell_reg) + 9'h1 == 9'(len_s_reg))
    ) else $error("setup phase length wrong");
  AST_CMD_LEN: assert property (@(posedge clk) disable iff (rst)
    (state_reg == ST_CMD && state_next == ST_RECOV) |-> (9'(dwell_reg) + 9'h1 >= 9'(len_c_reg))
    ) else $error("command phase too short");
  AST_RECOV_LEN: assert property (@(posedge clk) disable iff (rst)
    (state_reg == ST_RECOV && state_next == ST_IDLE) |-> (9'(dwell_reg) + 9'h1 == 9'(len_r_reg))
    ) else $error("recovery phase length wrong");
  AST_BASE_PERIOD: assert property (@(posedge clk) disable iff (rst)
    $rose(cmd_act) && !ctrl_reg[`PCCSE_CTRL_ENH_BIT] && cmd_reg.kind != KIND_DMA
    |-> tcyc_reg == TSTD
    ) else $error("standard mode period not used");
  AST_WAIT_TAIL: assert property (@(posedge clk) disable iff (rst)
    (state_reg == ST_CMD && $fell(wait_s)) |-> ##1 cmd_act [*2]
    ) else $error("command dropped too soon after wait release");
  AST_DACK_LEAD: assert property (@(posedge clk) disable iff (rst)
    $fell(card_pins.dack_n) |-> s_dack_lead
    ) else $error("acknowledge lead too short");
  AST_DMA_WR_W: assert property (@(posedge clk) disable iff (rst)
    $fell(card_pins.iow_n) && !card_pins.dack_n |-> !card_pins.iow_n [*5]
    ) else $error("DMA write command too short");
  AST_DMA_RD_W: assert property (@(posedge clk) disable iff (rst)
    $fell(card_pins.ior_n) && !card_pins.dack_n |-> !card_pins.ior_n [*8] ##1 !card_pins.ior_n [*6]
    ) else $error("DMA read command too short");
  AST_DACK_HOLD: assert property (@(posedge clk) disable iff (rst)
    $fell(cmd_act) && !card_pins.dack_n |-> !card_pins.dack_n [*2]
    ) else $error("acknowledge released too early");
  AST_TC: assert property (@(posedge clk) disable iff (rst)
    $fell(card_pins.tc_n) |-> $past(cmd_act) ##0 s_tc_pulse
    ) else $error("terminal count timing wrong");
  AST_ATTR_RD: assert property (@(posedge clk) disable iff (rst)
    cmd_act && cmd_reg.kind == KIND_ATTR |-> !card_pins.reg_n[cmd_reg.socket]
      && (card_pins.oe_n != card_pins.we_n) && (card_pins.we_n == !cmd_reg.write)
    ) else $error("attribute strobes wrong");
  AST_IO_REG: assert property (@(posedge clk) disable iff (rst)
    !card_pins.ior_n && card_pins.dack_n |-> !card_pins.reg_n[cmd_reg.socket] && card_pins.oe_n
    ) else $error("I/O cycle without attribute select");
  AST_ONE_SOCKET: assert property (@(posedge clk) disable iff (rst)
    !((card_pins.ce_lo_n[0] & card_pins.ce_hi_n[0]) | (card_pins.ce_lo_n[1] & card_pins.ce_hi_n[1]))
    |-> 1'b0
    ) else $error("both sockets enabled");
  AST_HI_LANE: assert property (@(posedge clk) disable iff (rst)
    $fell(card_pins.ce_hi_n[cmd_reg.socket]) && busy |-> ##0 (cmd_reg.width != WID_BYTE) || io16_s
    ) else $error("high lane enabled without cause");
endmodule // pccse_engine

// ===== pkg/pccse_params.svh
`ifndef PCCSE_PARAMS_SVH
`define PCCSE_PARAMS_SVH

// Clock and base periods
`define PCCSE_CLK_NS        50
`define PCCSE_T_STD_NS      125
`define PCCSE_T_ENH_NS      30
`define PCCSE_NS2CYC(ns)    (((ns) + `PCCSE_CLK_NS - 1) / `PCCSE_CLK_NS)
`define PCCSE_T_STD_CYC     `PCCSE_NS2CYC(`PCCSE_T_STD_NS)
`define PCCSE_T_ENH_CYC     `PCCSE_NS2CYC(`PCCSE_T_ENH_NS)

// DMA I/O timing, least times in ns
`define PCCSE_DACK_SU_NS    145
`define PCCSE_DMA_WR_NS     220
`define PCCSE_DMA_RD_NS     700
`define PCCSE_DACK_HOLD_NS  60
`define PCCSE_TC_DLY_NS     15
`define PCCSE_TC_W_NS       62
`define PCCSE_DACK_SU_CYC   `PCCSE_NS2CYC(`PCCSE_DACK_SU_NS)
`define PCCSE_DMA_WR_CYC    `PCCSE_NS2CYC(`PCCSE_DMA_WR_NS)
`define PCCSE_DMA_RD_CYC    `PCCSE_NS2CYC(`PCCSE_DMA_RD_NS)
`define PCCSE_DACK_HOLD_CYC `PCCSE_NS2CYC(`PCCSE_DACK_HOLD_NS)
`define PCCSE_TC_DLY_CYC    `PCCSE_NS2CYC(`PCCSE_TC_DLY_NS)
`define PCCSE_TC_W_CYC      `PCCSE_NS2CYC(`PCCSE_TC_W_NS)

// Register byte offsets
`define PCCSE_OFS_CTRL      8'h00
`define PCCSE_OFS_TSET0     8'h04
`define PCCSE_OFS_TSET3     8'h10
`define PCCSE_OFS_ADDR      8'h14
`define PCCSE_OFS_WDATA     8'h18
`define PCCSE_OFS_CMD       8'h1c
`define PCCSE_OFS_STATUS    8'h20

// Field positions
`define PCCSE_CTRL_ENH_BIT  0
`define PCCSE_TS_S_LSB      0
`define PCCSE_TS_C_LSB      8
`define PCCSE_TS_R_LSB      16
`define PCCSE_ST_RDATA_LSB  16

// Reset values
`define PCCSE_TSET_RST      18'h3ffff
`define PCCSE_CTRL_RST      3'h0

`endif

// ===== pkg/pccse_pkg.sv
package pccse_pkg;

  typedef enum logic [1:0] {KIND_ATTR, KIND_COMMON, KIND_IO, KIND_DMA} pccse_kind_t;
  typedef enum logic [1:0] {WID_BYTE, WID_WORD, WID_HIGH, WID_RSVD} pccse_width_t;

  typedef enum {ST_IDLE, ST_SETUP, ST_CMD, ST_RECOV, ST_DMA_ACK, ST_DMA_CMD, ST_DMA_HOLD}
    pccse_state_t;

  // One cycle request as written to the command register
  typedef struct packed {
    logic         last;
    logic         socket;
    pccse_width_t width;
    logic         write;
    pccse_kind_t  kind;
  } pccse_cmd_t;

  // Setup, command and recovery counts of one timing set
  typedef struct packed {
    logic [5:0] r;
    logic [5:0] c;
    logic [5:0] s;
  } pccse_tset_t;

  // Card-side strobes, all active low
  typedef struct packed {
    logic [1:0] ce_hi_n;
    logic [1:0] ce_lo_n;
    logic [1:0] reg_n;
    logic       oe_n;
    logic       we_n;
    logic       ior_n;
    logic       iow_n;
    logic       dack_n;
    logic       tc_n;
  } pccse_pins_t;

endpackage

// ===== logic/pccse_sync.sv
`timescale 1ns/10ps
// Two-stage synchroniser for pin inputs
module pccse_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_reg;

  // First stage feeds only the second stage
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule // pccse_sync

// ===== tb/pccse_card.sv
`timescale 1ns/10ps
// Card model: answers reads, stretches on request, claims word I/O
module pccse_card import pccse_pkg::*; (
  input  wire logic       clk,
  input  wire logic       rst,
  input  pccse_pins_t     card_pins,
  input  wire logic [7:0] stretch,
  input  wire logic       word_io,
  output logic     [15:0] data_in,
  output logic            wait_n,
  output logic            io16_n
);
  logic [7:0] cnt;
  logic       tog;
  logic       rd;
  logic       act;
  assign rd  = !card_pins.oe_n || !card_pins.ior_n;
  assign act = rd || !card_pins.we_n || !card_pins.iow_n;
  // Stretch counter loads while idle, so wait drops in the first command cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) cnt <= 8'h00;
    else if (!act) cnt <= stretch;
    else if (cnt != 8'h00) cnt <= cnt - 8'h01;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) tog <= 1'b0;
    else tog <= ~tog;
  end
  assign wait_n  = !(act && cnt != 8'h00);
  // Released bus toggles, so stale data can never pass for a good read
  assign data_in = rd ? 16'ha5c3 : (tog ? 16'h5a3c : 16'hffff);
  assign io16_n  = !(word_io && card_pins.ce_lo_n != 2'b11);
endmodule // pccse_card

// ===== tb/pc_card_socket_cycle_engine_tb.sv
`timescale 1ns/10ps
`include "pccse_params.svh"
module pc_card_socket_cycle_engine_tb import pccse_pkg::*;;
  typedef struct {
    pccse_kind_t k; logic w; pccse_width_t wd; logic sk; logic [1:0] hi, lo, rg;
  } pccse_row_t;
  logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, word_io = 0;
  logic pready, pslverr, oe, oes, wait_n, io16_n, err;
  logic [7:0]  paddr = 8'h00, stretch = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic [25:0] sab, a;
  logic [15:0] din, dout, dsee;
  logic [3:0]  stb_n, stb, stx;
  logic [1:0]  hi, lo, rg;
  pccse_pins_t pins;
  int failures = 0, num_checks = 0, s, c, h, tcc;
  pccse_row_t rows [7] = '{
    '{KIND_ATTR, 0, WID_BYTE, 0, 2'b11, 2'b10, 2'b10},
    '{KIND_ATTR, 1, WID_BYTE, 0, 2'b11, 2'b10, 2'b10},
    '{KIND_COMMON, 0, WID_BYTE, 0, 2'b11, 2'b10, 2'b11},
    '{KIND_COMMON, 0, WID_WORD, 0, 2'b10, 2'b10, 2'b11},
    '{KIND_COMMON, 1, WID_HIGH, 0, 2'b10, 2'b11, 2'b11},
    '{KIND_IO, 0, WID_BYTE, 1, 2'b11, 2'b01, 2'b01},
    '{KIND_IO, 1, WID_WORD, 0, 2'b10, 2'b10, 2'b10}};
  assign stb_n = {pins.oe_n, pins.we_n, pins.ior_n, pins.iow_n};
  always #25 clk = ~clk;
  pccse_engine dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .system_address_bus(sab), .system_data_bus_in(din), .system_data_bus_out(dout),
    .system_data_bus_oe(oe), .card_stretch_request_n(wait_n),
    .card_io_word_indication_n(io16_n), .card_pins(pins));
  pccse_card card (.clk(clk), .rst(rst), .card_pins(pins), .stretch(stretch),
    .word_io(word_io), .data_in(din), .wait_n(wait_n), .io16_n(io16_n));
  //////////////////////////////////////////////////////////////////
  task chk(input string n, input logic [31:0] e, input logic [31:0] v);
    num_checks++;
    if (v !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", n, e, v);
    end
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // One APB transfer; an idle edge after it keeps psel from being driven twice at once
  task apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= ad; pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    rdat = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge clk);
  endtask
  // Launch one card cycle and count setup, strobe, acknowledge hold and terminal count
  task run(input pccse_kind_t k, input logic w, input pccse_width_t wd, input logic sk,
           input logic last);
    pccse_cmd_t cmd;
    cmd = '{last: last, socket: sk, width: wd, write: w, kind: k};
    s = 0; c = 0; h = 0; tcc = 0;
    apb(1, `PCCSE_OFS_CMD, {25'h0, cmd});
    // Look before waiting: the first look still sees what the accepting edge launched
    for (int n = 0; n < 3000; n++) begin
      if (!pins.tc_n) tcc++;
      if (stb_n != 4'hf) begin
        c++;
        hi = pins.ce_hi_n;
        lo = pins.ce_lo_n;
        rg = pins.reg_n;
        a = sab;
        if (c == 1) begin
          stb = stb_n;
          dsee = dout;
          oes = oe;
        end
      end else if (c > 0 && !pins.dack_n) h++;
      else if (c > 0) break;
      else if (pins.ce_lo_n != 2'b11 || pins.ce_hi_n != 2'b11 || !pins.dack_n) s++;
      @(posedge clk);
    end
    do apb(0, `PCCSE_OFS_STATUS, 32'h0); while (rdat[0] !== 1'b0);
  endtask
  //////////////////////////////////////////////////////////////////
  initial begin
    #3000000;
    failures++;
    end_of_test;
  end
  initial begin
    repeat (12) @(posedge clk);
    chk("pins_reset", 32'hfff, {20'h0, pins});
    rst <= 0;
    @(posedge clk);
    apb(0, `PCCSE_OFS_TSET0, 32'h0);
    chk("tset0_reset", 32'h003f3f3f, rdat);
    apb(0, 8'hfc, 32'h0);
    chk("unmapped_err", 1, err);
    apb(1, `PCCSE_OFS_TSET0, 32'h00010201);
    apb(1, `PCCSE_OFS_ADDR, 32'h00000124);
    apb(1, `PCCSE_OFS_WDATA, 32'h0000beef);
    foreach (rows[i]) begin
      run(rows[i].k, rows[i].w, rows[i].wd, rows[i].sk, 0);
      chk("setup_cycles", 3, s);
      chk("cmd_cycles", 6, c);
      chk("address", 26'h124, a);
      stx = rows[i].k == KIND_IO ? (rows[i].w ? 4'he : 4'hd) : (rows[i].w ? 4'hb : 4'h7);
      chk("strobe", stx, stb);
      chk("lane_hi", rows[i].hi, hi);
      chk("lane_lo", rows[i].lo, lo);
      chk("attr_sel", rows[i].rg, rg);
      chk("drive_en", rows[i].w, oes);
      if (rows[i].w) chk("write_data", 16'hbeef, dsee);
      if (rows[i].wd == WID_WORD && !rows[i].w) chk("read_data", 16'ha5c3, rdat[31:16]);
      $display("row %0d done", i);
    end
    // Card stretches a read well past the programmed command time
    stretch <= 8'd10;
    run(KIND_COMMON, 0, WID_WORD, 0, 0);
    chk("stretch_len", 1, c >= 16);
    chk("stretch_data", 16'ha5c3, rdat[31:16]);
    stretch <= 8'd0;
    word_io <= 1;
    run(KIND_IO, 0, WID_BYTE, 0, 0);
    chk("io_word_hi", 2'b10, hi);
    chk("io_seen", 1, rdat[1]);
    word_io <= 0;
    $display("stretch and word I/O done");
    run(KIND_DMA, 0, WID_BYTE, 0, 1);
    chk("dack_lead", 3, s);
    chk("dma_rd_len", 14, c);
    chk("dack_hold", 2, h);
    chk("tc_len", 2, tcc);
    run(KIND_DMA, 1, WID_WORD, 0, 0);
    chk("dma_wr_len", 5, c);
    chk("tc_absent", 0, tcc);
    $display("dma done");
    // Enhanced clock with timing set three
    apb(1, `PCCSE_OFS_TSET3, 32'h00010102);
    apb(1, `PCCSE_OFS_CTRL, 32'h00000007);
    run(KIND_COMMON, 0, WID_BYTE, 1, 0);
    chk("enh_setup", 2, s);
    chk("enh_cmd", 1, c);
    $display("enhanced done");
    end_of_test;
  end
endmodule // pc_card_socket_cycle_engine_tb
